// ---- afe_pkg.sv ----
// Functional notes
// - Shift out on falling, sample on rising edge
// - Transaction spans one chip-select low period
// - Chip select high: output released, pins ignored
// - Chip select rise aborts, returns to idle
// - Serial pins cross domains through synchronisers
// - First byte is the command byte
// - Data frame width 16, 24 or 32 bits
// - Thirty-two register addresses
// - Address auto-advances through selected loop set
// - Optional CRC-16 after each read sequence
// - Writes other than to lock dropped unless lock equals password
// - Background CRC-16 over configuration words 0x07 to 0x18
// - Checksum change with alert drives ready low
// - Low pulse on ready pin for new data
// - Hard reset pin restores power-up defaults
// - Six per-channel ready flags in status register
// - Ready flags are read-only
// - Flags reset to one, drop on update
// - Status register read sets all flags
// - Linked flags update with lagging channel
// - Command: device bits, register bits, read bit
// - Read loop field selects address set
// - Bad-address write: no change, no advance
// - Linked: only lagging channel pulses pin
package afe_pkg;
   localparam int CLK_MHZ = 100;
   localparam int ADDR_W = 5;
   localparam int DATA_W = 24;
   localparam int NUM_REGS = 32;
   localparam int NUM_CH = 6;
   localparam int FIFO_DEPTH = 8;
   localparam logic [4:0] ADDR_CH_HI = 5'h05;
   localparam logic [4:0] ADDR_MOD = 5'h06;
   localparam logic [4:0] ADDR_STATUS = 5'h0A;
   localparam logic [4:0] ADDR_WR_HI = 5'h18;
   localparam logic [4:0] ADDR_LOCK = 5'h1F;
   localparam logic [4:0] ADDR_FIRST = 5'h00;
   localparam logic [7:0] LOCK_PASSWORD = 8'hA5;
   localparam logic [7:0] LOCK_RESET = 8'hA5;
   localparam logic [1:0] DEV_ADDR = 2'h1;
   localparam int STAT_RLOOP_LSB = 22;
   localparam int STAT_WLOOP = 21;
   localparam int STAT_WIDTH_LSB = 19;
   localparam int STAT_LINK = 18;
   localparam int STAT_RDCRC = 17;
   localparam int STAT_ALERT = 16;
   localparam logic [23:0] STATUS_RESET = 24'hAC0000;
   localparam logic [5:0] FLAGS_RESET = 6'h3F;
   localparam logic [15:0] CRC_POLY = 16'h8005;
   localparam logic [15:0] CRC_INIT = 16'h0000;
   localparam int PULSE_NS = 100;
   localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS * CLK_MHZ + 999) / 1000);
   localparam logic [4:0] LAST_BIT_16 = 5'h0F;
   localparam logic [4:0] LAST_BIT_24 = 5'h17;
   localparam logic [4:0] LAST_BIT_32 = 5'h1F;
   localparam logic [2:0] CMD_BITS_LAST = 3'h7;

   typedef enum logic [2:0] {
      ST_CMD   = 3'b000,
      ST_READ  = 3'b001,
      ST_WRITE = 3'b010,
      ST_CRC   = 3'b011,
      ST_SKIP  = 3'b100
   } spi_state_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } wr_req_t;

   function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din);
      crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ din) ? CRC_POLY : 16'h0000);
   endfunction : crc_step
endpackage : afe_pkg

// ---- afe_wr_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module afe_wr_fifo #(
   parameter int WIDTH = 29,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_in,
   // Fill side
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0]      wr_ptr;
   logic [AW:0]      rd_ptr;
   wire              empty = (wr_ptr == rd_ptr);
   wire              full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
   wire              push = in_valid_in && !full;
   wire              pop = out_ready_in && !empty;

   assign in_ready_out = !full;
   assign out_valid_out = !empty;
   assign out_data_out = mem[rd_ptr[AW-1:0]];

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= in_data_in;
      end
   end
endmodule : afe_wr_fifo
`default_nettype wire

// ---- afe_cfg_crc.sv ----
`timescale 1ns/1ps
`default_nettype none
module afe_cfg_crc (
   // Clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   // Register walk
   output logic [4:0]       idx_out,
   input  wire logic [23:0] word_in,
   // Result
   output logic [15:0]      crc_out,
   output logic             changed_out
);
   logic [15:0] acc;
   logic        valid;

   function automatic logic [15:0] crc_word(input logic [15:0] crc, input logic [23:0] w);
      logic [15:0] c;
      c = crc;
      for (int i = 23; i >= 0; i--) begin
         c = afe_pkg::crc_step(c, w[i]);
      end
      crc_word = c;
   endfunction : crc_word

   // Modulator output and lock/checksum words stay out of the sum
   wire         included = (idx_out > afe_pkg::ADDR_MOD) && (idx_out <= afe_pkg::ADDR_WR_HI);
   wire  [15:0] acc_next = included ? crc_word(acc, word_in) : acc;
   wire         pass_end = (idx_out == afe_pkg::ADDR_LOCK);

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         idx_out <= afe_pkg::ADDR_FIRST;
         acc <= afe_pkg::CRC_INIT;
         crc_out <= afe_pkg::CRC_INIT;
         valid <= 1'b0;
         changed_out <= 1'b0;
      end else begin
         idx_out <= idx_out + 1'b1;
         acc <= pass_end ? afe_pkg::CRC_INIT : acc_next;
         changed_out <= pass_end && valid && (acc_next != crc_out);
         if (pass_end) begin
            crc_out <= acc_next;
            valid <= 1'b1;
         end
      end
   end
endmodule : afe_cfg_crc
`default_nettype wire

// ---- afe_spi_host_port.sv ----
`timescale 1ns/1ps
`default_nettype none
module afe_spi_host_port (
   // Clock and resets
   input  wire logic                                          REF_CLK_IN,
   input  wire logic                                          SYS_RST_IN,
   input  wire logic                                          RESET_N_IN,
   // Serial pins
   input  wire logic                                          CS_N_IN,
   input  wire logic                                          SCK_IN,
   input  wire logic                                          SERIAL_IN_IN,
   output logic                                               SERIAL_OUT_OUT,
   output logic                                               SERIAL_OUT_OE_N_OUT,
   // Converter side
   input  wire logic [afe_pkg::NUM_CH-1:0][afe_pkg::DATA_W-1:0] CHAN_DATA_IN,
   input  wire logic [afe_pkg::NUM_CH-1:0]                    CHAN_UPDATE_IN,
   input  wire logic [afe_pkg::NUM_CH-1:0]                    CHAN_ACTIVE_IN,
   // Data ready pin
   output logic                                               READY_PULSE_PIN_N_OUT
);
   logic [1:0]  rstn_s;
   logic [1:0]  cs_s;
   logic [2:0]  sck_s;
   logic [1:0]  sdi_s;
   afe_pkg::spi_state_t state;
   logic [7:0]  cmd;
   logic [2:0]  cmd_cnt;
   logic [4:0]  addr;
   logic [4:0]  bit_cnt;
   logic [31:0] tx;
   logic [31:0] rx;
   logic [15:0] crc_acc;
   logic        is_read;
   logic [23:0] cfg [afe_pkg::NUM_REGS];
   logic [7:0]  lock;
   logic [5:0]  flags;
   logic [23:0] vis [afe_pkg::NUM_CH];
   logic [23:0] hold [afe_pkg::NUM_CH];
   logic [5:0]  seen;
   logic [7:0]  pulse_cnt;
   logic        alert;
   logic        pend_valid;
   afe_pkg::wr_req_t pend_req;
   afe_pkg::wr_req_t fifo_out;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic [4:0]  crc_idx;
   logic [15:0] cfg_crc;
   logic        crc_changed;

   function automatic logic writable(input logic [4:0] a);
      writable = ((a >= afe_pkg::ADDR_MOD) && (a <= afe_pkg::ADDR_WR_HI))
                 || (a == afe_pkg::ADDR_LOCK);
   endfunction : writable

   function automatic logic [4:0] last_bit(input logic [1:0] w);
      last_bit = (w == 2'h0) ? afe_pkg::LAST_BIT_16 :
                 (w == 2'h1) ? afe_pkg::LAST_BIT_24 : afe_pkg::LAST_BIT_32;
   endfunction : last_bit

   // Loop set as {first, last} address
   function automatic logic [9:0] loop_set(input logic [4:0] a, input logic [1:0] rmode,
                                           input logic wloop, input logic rd);
      logic ch;
      ch = (a <= afe_pkg::ADDR_CH_HI);
      if (!rd) begin
         loop_set = wloop ? {afe_pkg::ADDR_MOD, afe_pkg::ADDR_LOCK} : {a, a};
      end else begin
         unique case (rmode)
            2'h0: loop_set = {a, a};
            2'h1: loop_set = ch ? {a & 5'h1E, a | 5'h01} : {afe_pkg::ADDR_MOD, afe_pkg::ADDR_STATUS};
            2'h2: loop_set = ch ? {afe_pkg::ADDR_FIRST, afe_pkg::ADDR_CH_HI}
                                : {afe_pkg::ADDR_MOD, afe_pkg::ADDR_LOCK};
            2'h3: loop_set = {afe_pkg::ADDR_FIRST, afe_pkg::ADDR_LOCK};
         endcase
      end
   endfunction : loop_set

   // Resets and synchronisers
   wire rst = SYS_RST_IN || !rstn_s[1];
   always_ff @(posedge REF_CLK_IN) begin
      if (SYS_RST_IN) begin
         rstn_s <= 2'h0;
      end else begin
         rstn_s <= {rstn_s[0], RESET_N_IN};
      end
   end
   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         cs_s <= 2'h3;
         sck_s <= 3'h0;
         sdi_s <= 2'h0;
      end else begin
         cs_s <= {cs_s[0], CS_N_IN};
         sck_s <= {sck_s[1:0], SCK_IN};
         sdi_s <= {sdi_s[0], SERIAL_IN_IN};
      end
   end

   wire        deselect = cs_s[1];
   wire        sck_rise = !deselect && sck_s[1] && !sck_s[2];
   wire        sck_fall = !deselect && !sck_s[1] && sck_s[2];
   wire        serial_in = sdi_s[1];

   // Configuration decode
   wire [23:0] stat = cfg[afe_pkg::ADDR_STATUS];
   wire [1:0]  rmode = stat[afe_pkg::STAT_RLOOP_LSB +: 2];
   wire        wloop = stat[afe_pkg::STAT_WLOOP];
   wire [1:0]  width = stat[afe_pkg::STAT_WIDTH_LSB +: 2];
   wire        linked = stat[afe_pkg::STAT_LINK];
   wire        rdcrc_en = stat[afe_pkg::STAT_RDCRC];
   wire        alert_en = stat[afe_pkg::STAT_ALERT];

   // Read path
   wire        is_ch = (addr <= afe_pkg::ADDR_CH_HI);
   wire [23:0] rd_word = is_ch ? vis[addr[2:0]] :
                         (addr == afe_pkg::ADDR_STATUS) ? {stat[23:6], flags} :
                         (addr == afe_pkg::ADDR_LOCK) ? {lock, cfg_crc} :
                         writable(addr) ? cfg[addr] : 24'h000000;
   wire [31:0] rd_frame = (width == 2'h0) ? {rd_word[23:8], 16'h0000} :
                          (width == 2'h3) ? {{8{rd_word[23]}}, rd_word} :
                          {rd_word, 8'h00};
   wire [31:0] wr_rx = {rx[30:0], serial_in};
   wire [23:0] wr_val = (width == 2'h0) ? {wr_rx[15:0], 8'h00} :
                        (width == 2'h2) ? wr_rx[31:8] : wr_rx[23:0];
   wire [9:0]  lset = loop_set(addr, rmode, wloop, is_read);
   wire [4:0]  set_lo = lset[9:5];
   wire        seq_end = (addr == lset[4:0]);
   wire [4:0]  next_addr = seq_end ? set_lo : addr + 5'h01;
   wire        frame_load = (state == afe_pkg::ST_READ) && sck_fall && (bit_cnt == 5'h00);
   wire        frame_last = (bit_cnt == last_bit(width));
   wire        crc_last = (bit_cnt == afe_pkg::LAST_BIT_16);
   wire        shift_out = frame_load ? rd_frame[31] : tx[31];
   wire        rd_status = frame_load && (addr == afe_pkg::ADDR_STATUS);
   wire        rd_lock = frame_load && (addr == afe_pkg::ADDR_LOCK);
   wire        cmd_done = sck_rise && (cmd_cnt == afe_pkg::CMD_BITS_LAST);
   wire [7:0]  cmd_full = {cmd[6:0], serial_in};

   // Serial state machine
   always_ff @(posedge REF_CLK_IN) begin
      if (rst || deselect) begin
         state <= afe_pkg::ST_CMD;
         cmd <= 8'h00;
         cmd_cnt <= 3'h0;
         addr <= 5'h00;
         bit_cnt <= 5'h00;
         tx <= 32'h00000000;
         rx <= 32'h00000000;
         crc_acc <= afe_pkg::CRC_INIT;
         is_read <= 1'b0;
      end else begin
         unique case (state)
            afe_pkg::ST_CMD: begin
               if (sck_rise) begin
                  cmd <= cmd_full;
                  cmd_cnt <= cmd_cnt + 3'h1;
               end
               if (cmd_done) begin
                  addr <= cmd_full[5:1];
                  is_read <= cmd_full[0];
                  if (cmd_full[7:6] != afe_pkg::DEV_ADDR) begin
                     state <= afe_pkg::ST_SKIP;
                  end else begin
                     state <= cmd_full[0] ? afe_pkg::ST_READ : afe_pkg::ST_WRITE;
                  end
               end
            end
            afe_pkg::ST_READ: begin
               if (sck_fall) begin
                  tx <= frame_load ? {rd_frame[30:0], 1'b0} : {tx[30:0], 1'b0};
                  crc_acc <= afe_pkg::crc_step(crc_acc, shift_out);
                  bit_cnt <= frame_last ? 5'h00 : bit_cnt + 5'h01;
                  if (frame_last) begin
                     addr <= next_addr;
                     if (seq_end && rdcrc_en) begin
                        state <= afe_pkg::ST_CRC;
                     end
                  end
               end
            end
            afe_pkg::ST_CRC: begin
               if (sck_fall) begin
                  tx <= (bit_cnt == 5'h00) ? {crc_acc[14:0], 17'h00000} : {tx[30:0], 1'b0};
                  bit_cnt <= crc_last ? 5'h00 : bit_cnt + 5'h01;
                  if (crc_last) begin
                     crc_acc <= afe_pkg::CRC_INIT;
                     state <= afe_pkg::ST_READ;
                  end
               end
            end
            afe_pkg::ST_WRITE: begin
               if (sck_rise) begin
                  rx <= wr_rx;
                  bit_cnt <= frame_last ? 5'h00 : bit_cnt + 5'h01;
                  if (frame_last && writable(addr)) begin
                     addr <= next_addr;
                  end
               end
            end
            afe_pkg::ST_SKIP: begin
               bit_cnt <= 5'h00;
            end
            default: begin
               state <= afe_pkg::ST_CMD;
            end
         endcase
      end
   end

   // Serial output; released during command, write and skip
   wire crc_bit = (bit_cnt == 5'h00) ? crc_acc[15] : tx[31];
   always_ff @(posedge REF_CLK_IN) begin
      if (rst || deselect) begin
         SERIAL_OUT_OUT <= 1'b0;
         SERIAL_OUT_OE_N_OUT <= 1'b1;
      end else if (sck_fall && (state == afe_pkg::ST_READ)) begin
         SERIAL_OUT_OUT <= shift_out;
         SERIAL_OUT_OE_N_OUT <= 1'b0;
      end else if (sck_fall && (state == afe_pkg::ST_CRC)) begin
         SERIAL_OUT_OUT <= crc_bit;
         SERIAL_OUT_OE_N_OUT <= 1'b0;
      end
   end

   // Completed write words wait here until the FIFO takes them
   wire wr_done = (state == afe_pkg::ST_WRITE) && sck_rise && frame_last && writable(addr);
   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         pend_valid <= 1'b0;
         pend_req <= '0;
      end else if (wr_done) begin
         pend_valid <= 1'b1;
         pend_req <= '{addr: addr, data: wr_val};
      end else if (fifo_in_ready) begin
         pend_valid <= 1'b0;
      end
   end

   // Drain stalls while a frame loads so the read mux is stable
   wire drain = fifo_out_valid && !frame_load;
   afe_wr_fifo #(
      .WIDTH ($bits(afe_pkg::wr_req_t)),
      .DEPTH (afe_pkg::FIFO_DEPTH)
   ) u_wr_fifo (
      .clk_in        (REF_CLK_IN),
      .rst_in        (rst),
      .in_valid_in   (pend_valid),
      .in_ready_out  (fifo_in_ready),
      .in_data_in    (pend_req),
      .out_valid_out (fifo_out_valid),
      .out_ready_in  (drain),
      .out_data_out  (fifo_out)
   );

   // Register file; the lock word is always writable so software can unlock
   wire unlocked = (lock == afe_pkg::LOCK_PASSWORD);
   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         for (int i = 0; i < afe_pkg::NUM_REGS; i++) begin
            cfg[i] <= (i == int'(afe_pkg::ADDR_STATUS)) ? afe_pkg::STATUS_RESET : 24'h000000;
         end
         lock <= afe_pkg::LOCK_RESET;
      end else if (drain) begin
         if (fifo_out.addr == afe_pkg::ADDR_LOCK) begin
            lock <= fifo_out.data[23:16];
         end else if (unlocked) begin
            cfg[fifo_out.addr] <= fifo_out.data;
         end
      end
   end

   afe_cfg_crc u_cfg_crc (
      .clk_in      (REF_CLK_IN),
      .rst_in      (rst),
      .idx_out     (crc_idx),
      .word_in     (cfg[crc_idx]),
      .crc_out     (cfg_crc),
      .changed_out (crc_changed)
   );

   // Channel capture and linking
   wire [5:0] seen_now = seen | CHAN_UPDATE_IN;
   wire       link_evt = (CHAN_ACTIVE_IN != 6'h00) && ((seen_now & CHAN_ACTIVE_IN) == CHAN_ACTIVE_IN);
   wire       pulse_trig = linked ? link_evt : |(CHAN_UPDATE_IN & CHAN_ACTIVE_IN);
   wire [5:0] evt_mask = linked ? (link_evt ? 6'h3F : 6'h00) : CHAN_UPDATE_IN;
   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         seen <= 6'h00;
         for (int i = 0; i < afe_pkg::NUM_CH; i++) begin
            hold[i] <= 24'h000000;
            vis[i] <= 24'h000000;
         end
      end else begin
         seen <= link_evt ? 6'h00 : seen_now;
         for (int i = 0; i < afe_pkg::NUM_CH; i++) begin
            if (CHAN_UPDATE_IN[i]) begin
               hold[i] <= CHAN_DATA_IN[i];
            end
            if (linked ? link_evt : CHAN_UPDATE_IN[i]) begin
               vis[i] <= CHAN_UPDATE_IN[i] ? CHAN_DATA_IN[i] : hold[i];
            end
         end
      end
   end

   // Ready flags: a data update beats a same-cycle status read
   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         flags <= afe_pkg::FLAGS_RESET;
      end else begin
         flags <= (rd_status ? afe_pkg::FLAGS_RESET : flags) & ~evt_mask;
      end
   end

   // Ready pin: pulse stretcher plus latched configuration alert
   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         pulse_cnt <= 8'h00;
         alert <= 1'b0;
      end else begin
         if (pulse_trig) begin
            pulse_cnt <= afe_pkg::PULSE_CYC;
         end else if (pulse_cnt != 8'h00) begin
            pulse_cnt <= pulse_cnt - 8'h01;
         end
         alert <= alert_en && (crc_changed || (alert && !rd_lock));
      end
   end

   always_ff @(posedge REF_CLK_IN) begin
      if (rst) begin
         READY_PULSE_PIN_N_OUT <= 1'b1;
      end else begin
         READY_PULSE_PIN_N_OUT <= !(pulse_trig || (pulse_cnt > 8'h01) || alert);
      end
   end
endmodule : afe_spi_host_port
`default_nettype wire

// ---- afe_spi_host_port_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
module afe_spi_host_port_asserts (
   // Clock and resets
   input wire logic                        REF_CLK_IN,
   input wire logic                        SYS_RST_IN,
   input wire logic                        RESET_N_IN,
   // Serial pins
   input wire logic                        CS_N_IN,
   input wire logic                        SCK_IN,
   input wire logic                        SERIAL_OUT_OUT,
   input wire logic                        SERIAL_OUT_OE_N_OUT,
   // Converter side and ready pin
   input wire logic [afe_pkg::NUM_CH-1:0] CHAN_UPDATE_IN,
   input wire logic [afe_pkg::NUM_CH-1:0] CHAN_ACTIVE_IN,
   input wire logic                        READY_PULSE_PIN_N_OUT
);
   logic [7:0] low_cnt;
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (SYS_RST_IN || !RESET_N_IN);
   // Counts the low run of the ready pin
   always_ff @(posedge REF_CLK_IN) begin
      low_cnt <= READY_PULSE_PIN_N_OUT ? 8'h00 : low_cnt + 8'h01;
   end
   reset_sync_a: assert property ($fell(SYS_RST_IN) |-> SERIAL_OUT_OE_N_OUT &&
      READY_PULSE_PIN_N_OUT && !SERIAL_OUT_OUT) else $error("sync reset values");
   reset_pin_a: assert property ($rose(RESET_N_IN) |-> SERIAL_OUT_OE_N_OUT &&
      READY_PULSE_PIN_N_OUT) else $error("hard reset values");
   cs_hiz_a: assert property (CS_N_IN [*5] |-> SERIAL_OUT_OE_N_OUT)
      else $error("output driven while deselected");
   oe_start_a: assert property ($fell(SERIAL_OUT_OE_N_OUT) |-> !CS_N_IN && !SCK_IN)
      else $error("output enabled off a falling edge");
   out_fall_a: assert property ($changed(SERIAL_OUT_OUT) && !SERIAL_OUT_OE_N_OUT |-> !SCK_IN)
      else $error("output bit changed with clock high");
   ready_pulse_a: assert property ((CHAN_UPDATE_IN & CHAN_ACTIVE_IN) == CHAN_ACTIVE_IN &&
      |CHAN_ACTIVE_IN |=> !READY_PULSE_PIN_N_OUT [*8]) else $error("ready pulse missing");
   ready_len_a: assert property ($rose(READY_PULSE_PIN_N_OUT) |-> low_cnt == afe_pkg::PULSE_CYC)
      else $error("ready pulse length");
   ready_cause_a: assert property ($fell(READY_PULSE_PIN_N_OUT) |->
      $past(|(CHAN_UPDATE_IN & CHAN_ACTIVE_IN))) else $error("ready pulse without update");
   cover property ($fell(READY_PULSE_PIN_N_OUT));
   cover property ($fell(SERIAL_OUT_OE_N_OUT));
   cover property ($rose(RESET_N_IN));
endmodule : afe_spi_host_port_asserts
bind afe_spi_host_port afe_spi_host_port_asserts afe_spi_host_port_asserts_i (
   .REF_CLK_IN(REF_CLK_IN),
   .SYS_RST_IN(SYS_RST_IN),
   .RESET_N_IN(RESET_N_IN),
   .CS_N_IN(CS_N_IN),
   .SCK_IN(SCK_IN),
   .SERIAL_OUT_OUT(SERIAL_OUT_OUT),
   .SERIAL_OUT_OE_N_OUT(SERIAL_OUT_OE_N_OUT),
   .CHAN_UPDATE_IN(CHAN_UPDATE_IN),
   .CHAN_ACTIVE_IN(CHAN_ACTIVE_IN),
   .READY_PULSE_PIN_N_OUT(READY_PULSE_PIN_N_OUT)
);
`default_nettype wire

// ---- afe_spi_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module afe_spi_host_model (
   // Serial pins
   output logic      cs_n_out,
   output logic      sck_out,
   output logic      sdi_out,
   input  wire logic sdo_in,
   input  wire logic sdo_oe_n_in
);
   logic [63:0] rx;
   logic        oe_seen;
   initial begin
      cs_n_out = 1'b1;
      sck_out = 1'b0;
      sdi_out = 1'b0;
   end
   // Idle level only moves while deselected
   task automatic xfer(input logic mode, input logic [63:0] tx, input int n);
      sck_out = mode;
      #200;
      cs_n_out = 1'b0;
      rx = 64'h0;
      oe_seen = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         #80;
         sck_out = 1'b0;
         sdi_out = tx[i];
         #80;
         sck_out = 1'b1;
         rx = {rx[62:0], sdo_oe_n_in ? !sdo_in : sdo_in};
         oe_seen = oe_seen | !sdo_oe_n_in;
      end
      #80;
      sck_out = mode;
      #80;
      cs_n_out = 1'b1;
      // Released line must not keep the last bit
      sdi_out = !sdi_out;
   endtask : xfer
endmodule : afe_spi_host_model
`default_nettype wire

// ---- afe_spi_host_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module afe_spi_host_port_tb;
   localparam logic [63:0] stat_idle = 64'({afe_pkg::STATUS_RESET[23:6], afe_pkg::FLAGS_RESET});
   localparam logic [63:0] stat_rdy = 64'(afe_pkg::STATUS_RESET);
   localparam logic [4:0]  st = afe_pkg::ADDR_STATUS;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic rst_n = 1'b1;
   logic cs_n, sck, serial_in, serial_out, oe_n, ready_n;
   logic [afe_pkg::NUM_CH-1:0][afe_pkg::DATA_W-1:0] chan_data = '0;
   logic [afe_pkg::NUM_CH-1:0] chan_update = '0;
   logic [afe_pkg::NUM_CH-1:0] chan_active = 6'h3F;
   logic mode = 1'b0;
   int   fail_count = 0;
   int   total_checks = 0;
   always #5 clk = !clk;
   afe_spi_host_port afe_spi_host_port_i (
      .REF_CLK_IN(clk),
      .SYS_RST_IN(rst),
      .RESET_N_IN(rst_n),
      .CS_N_IN(cs_n),
      .SCK_IN(sck),
      .SERIAL_IN_IN(serial_in),
      .SERIAL_OUT_OUT(serial_out),
      .SERIAL_OUT_OE_N_OUT(oe_n),
      .CHAN_DATA_IN(chan_data),
      .CHAN_UPDATE_IN(chan_update),
      .CHAN_ACTIVE_IN(chan_active),
      .READY_PULSE_PIN_N_OUT(ready_n)
   );
   afe_spi_host_model afe_spi_host_model_i (
      .cs_n_out(cs_n),
      .sck_out(sck),
      .sdi_out(serial_in),
      .sdo_in(serial_out),
      .sdo_oe_n_in(oe_n)
   );
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : check
   function automatic logic [7:0] cmd(input logic [4:0] a, input logic rd);
      return {afe_pkg::DEV_ADDR, a, rd};
   endfunction : cmd
   function automatic logic [15:0] crc16(input logic [15:0] d);
      logic [15:0] c;
      c = afe_pkg::CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? afe_pkg::CRC_POLY : 16'h0000);
      end
      return c;
   endfunction : crc16
   task automatic io(input logic [7:0] c, input logic [63:0] d, input int n);
      @(posedge clk);
      #1 afe_spi_host_model_i.xfer(mode, (64'(c) << n) | d, n + 8);
   endtask : io
   task automatic rd(input logic [4:0] a, input int n, input logic [63:0] exp, input string what);
      io(cmd(a, 1'b1), 64'h0, n);
      check(afe_spi_host_model_i.rx & ((64'h1 << n) - 64'h1), exp, what);
   endtask : rd
   task automatic upd(input logic [5:0] m, input logic exp_n);
      @(posedge clk);
      #1 chan_update = m;
      @(posedge clk);
      #1 chan_update = '0;
      check(64'(ready_n), 64'(exp_n), "ready pin");
      repeat (20) @(posedge clk);
   endtask : upd
   task automatic t_defaults;
      rd(st, 24, stat_idle, "status at reset");
      io({2'b00, st, 1'b1}, 64'h0, 24);
      check(64'(afe_spi_host_model_i.oe_seen), 64'h0, "foreign read drove");
   endtask : t_defaults
   task automatic t_flags;
      upd(6'h01, 1'b1);
      rd(st, 24, stat_idle, "lagging channel");
      upd(6'h3E, 1'b0);
      rd(st, 24, stat_rdy, "flags not cleared");
      rd(st, 24, stat_idle, "read did not set");
      upd(6'h3F, 1'b0);
      rd(afe_pkg::ADDR_FIRST, 24, 64'h00C0FFEE, "channel word");
   endtask : t_flags
   task automatic t_writes;
      mode = 1'b1;
      io(cmd(5'h07, 1'b0), {24'h123456, 24'h654321}, 48);
      rd(5'h07, 48, {16'h0, 24'h123456, 24'h654321}, "looped words");
      io(cmd(st, 1'b0), stat_idle, 24);
      rd(st, 24, stat_rdy, "flags written");
      io(cmd(5'h07, 1'b0), 64'h0ABC, 12);
      rd(5'h07, 24, 64'h123456, "partial frame");
      io(cmd(afe_pkg::ADDR_LOCK, 1'b0), 64'h0, 24);
      io(cmd(5'h07, 1'b0), 64'hABCDEF, 24);
      rd(5'h07, 24, 64'h123456, "locked write");
   endtask : t_writes
   task automatic t_hard_reset;
      mode = 1'b0;
      @(posedge clk);
      #1 rst_n = 1'b0;
      repeat (5) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (5) @(posedge clk);
      rd(5'h07, 24, 64'h0, "hard reset word");
      io(cmd(5'h07, 1'b0), 64'h777777, 24);
      rd(5'h07, 24, 64'h777777, "lock not restored");
   endtask : t_hard_reset
   // Static read loop, write loop on, 16-bit frames, read checksum on, linking off
   task automatic t_modes;
      io(cmd(st, 1'b0), 64'h220000, 24);
      io(cmd(5'h07, 1'b0), 64'hBEEF, 16);
      rd(5'h07, 32, {16'hBEEF, crc16(16'hBEEF)}, "crc frame");
      upd(6'h01, 1'b0);
   endtask : t_modes
   task automatic conclude;
      if (fail_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude
   initial begin
      chan_data[0] = 24'hC0FFEE;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      repeat (3) @(posedge clk);
      t_defaults();
      t_flags();
      t_writes();
      t_hard_reset();
      t_modes();
      conclude();
   end
   initial begin
      #500000;
      fail_count++;
      conclude();
   end
endmodule : afe_spi_host_port_tb
`default_nettype wire
